// ---- hw/fifo_mailbox_busmatch_retransmit.sv ----
// Purpose: mailbox bypass registers, port b bus matching and replay for a
//   unidirectional 36-bit fifo; port a writes, port b reads
// Assumes: port clocks are slow pins sampled by clock (100 MHz)
// Notes: standard output mode only; mail flags react one clock after a transfer, fifo flags two
//
// Function
// - two 36-bit mail registers bypass the queue
// - port a mail write loads mail_to_b_reg
// - port b mail write loads mail_to_a_reg
// - mail stores only lanes of bus size
// - mail write drops flag; later writes ignored
// - port b output shows fifo or mail per box select; port a shows mail
// - port b mail read raises mail_to_b_flag
// - port a mail read raises mail_to_a_flag
// - mail unchanged by reads and by endian
// - size and endian take effect before space flag
// - endian latched at master reset rise
// - memory holds full long-words; match after read
// - mail passes only on selected lanes
// - narrow reads present rest of long-word
// - unused port b lanes are indeterminate
// - replay only in standard output mode
// - replay low rewinds read pointer to zero
// - after replay reads rerun data to writer
// - flags recomputed from pointers during replay
// - port a select, direction and gate decode
// - port b select, direction and gate decode
// - word and byte order follow endian
// - bus match low forces long-word width
`timescale 1ns/1ps
module fifo_mailbox_busmatch_retransmit (
  input wire logic clock,
  input wire logic rstn,
  input wire logic port_a_clock,
  input wire logic port_a_chip_sel_n,
  input wire logic port_a_direction,
  input wire logic port_a_xfer_gate,
  input wire logic port_a_box_select,
  input wire logic [35:0] port_a_data_in,
  output logic [35:0] port_a_data_out,
  output logic port_a_data_oe,
  input wire logic port_b_clock,
  input wire logic port_b_chip_sel_n,
  input wire logic port_b_direction,
  input wire logic port_b_xfer_gate,
  input wire logic port_b_box_select,
  input wire logic [35:0] port_b_data_in,
  output logic [35:0] port_b_data_out,
  output logic port_b_data_oe,
  input wire logic master_reset_pins_n,
  input wire logic bus_match_select,
  input wire logic port_b_size_select,
  input wire logic big_endian_select,
  input wire logic replay_strobe_n,
  output logic mail_to_b_flag,
  output logic mail_to_a_flag,
  output logic space_avail_flag,
  output logic fifo_data_flag
);

  // ==========================================================
  // pin synchronisers
  logic [fifo_mbx_pkg::A_GROUP_W-1:0] a_sync;
  logic [fifo_mbx_pkg::B_GROUP_W-1:0] b_sync;
  logic [fifo_mbx_pkg::CFG_GROUP_W-1:0] cfg_sync;
  logic a_clk_s;
  logic a_cs_n_s;
  logic a_dir_s;
  logic a_gate_s;
  logic a_box_s;
  logic [35:0] a_data_s;
  logic b_clk_s;
  logic b_cs_n_s;
  logic b_dir_s;
  logic b_gate_s;
  logic b_box_s;
  logic [35:0] b_data_s;
  logic mrs_n_s;
  logic match_s;
  logic size_s;
  logic endian_s;
  logic replay_n_s;

  pin_sync #(
    .WIDTH(fifo_mbx_pkg::A_GROUP_W)
  ) u_sync_a (
    .clock(clock),
    .rstn(rstn),
    .async_in({port_a_clock, port_a_chip_sel_n, port_a_direction, port_a_xfer_gate,
      port_a_box_select, port_a_data_in}),
    .sync_out(a_sync)
  );

  pin_sync #(
    .WIDTH(fifo_mbx_pkg::B_GROUP_W)
  ) u_sync_b (
    .clock(clock),
    .rstn(rstn),
    .async_in({port_b_clock, port_b_chip_sel_n, port_b_direction, port_b_xfer_gate,
      port_b_box_select, port_b_data_in}),
    .sync_out(b_sync)
  );

  pin_sync #(
    .WIDTH(fifo_mbx_pkg::CFG_GROUP_W)
  ) u_sync_cfg (
    .clock(clock),
    .rstn(rstn),
    .async_in({master_reset_pins_n, bus_match_select, port_b_size_select,
      big_endian_select, replay_strobe_n}),
    .sync_out(cfg_sync)
  );

  assign {a_clk_s, a_cs_n_s, a_dir_s, a_gate_s, a_box_s, a_data_s} = a_sync;
  assign {b_clk_s, b_cs_n_s, b_dir_s, b_gate_s, b_box_s, b_data_s} = b_sync;
  assign {mrs_n_s, match_s, size_s, endian_s, replay_n_s} = cfg_sync;

  // ==========================================================
  // edge finding on sampled port clocks and master reset
  logic a_clk_prev_q;
  logic b_clk_prev_q;
  logic mrs_prev_q;
  logic a_rise;
  logic b_rise;
  logic mrs_rise;
  logic in_mrs;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      a_clk_prev_q <= 1'b0;
      b_clk_prev_q <= 1'b0;
      mrs_prev_q <= 1'b0;
    end
    else
    begin
      a_clk_prev_q <= a_clk_s;
      b_clk_prev_q <= b_clk_s;
      mrs_prev_q <= mrs_n_s;
    end
  end

  assign a_rise = a_clk_s & ~a_clk_prev_q;
  assign b_rise = b_clk_s & ~b_clk_prev_q;
  assign mrs_rise = mrs_n_s & ~mrs_prev_q;
  assign in_mrs = ~mrs_n_s;

  // ==========================================================
  // configuration, caught at the end of master reset
  fifo_mbx_pkg::bus_width_t width_q;
  logic big_endian_q;
  logic [35:0] lane_mask;

  // inputs assumed static after this point, so no re-sampling later
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      width_q <= fifo_mbx_pkg::WIDTH_RESET;
      big_endian_q <= fifo_mbx_pkg::ENDIAN_RESET;
    end
    else if (mrs_rise)
    begin
      big_endian_q <= endian_s;
      if (!match_s)
        width_q <= fifo_mbx_pkg::width_long;
      else if (!size_s)
        width_q <= fifo_mbx_pkg::width_word;
      else
        width_q <= fifo_mbx_pkg::width_byte;
    end
  end

  always_comb
  begin
    case (width_q)
      fifo_mbx_pkg::width_word: lane_mask = fifo_mbx_pkg::MASK_WORD;
      fifo_mbx_pkg::width_byte: lane_mask = fifo_mbx_pkg::MASK_BYTE;
      default: lane_mask = fifo_mbx_pkg::MASK_LONG;
    endcase
  end

  // ==========================================================
  // port decode
  logic a_sel;
  logic b_sel;
  logic a_mail_wr;
  logic a_mail_rd;
  logic a_fifo_wr;
  logic b_mail_wr;
  logic b_mail_rd;
  logic b_fifo_rd;

  assign a_sel = a_rise & ~a_cs_n_s & a_gate_s;
  assign b_sel = b_rise & ~b_cs_n_s & b_gate_s;
  assign a_mail_wr = a_sel & a_dir_s & a_box_s;
  assign a_fifo_wr = a_sel & a_dir_s & ~a_box_s;
  assign a_mail_rd = a_sel & ~a_dir_s & a_box_s;
  assign b_mail_wr = b_sel & ~b_dir_s & b_box_s;
  assign b_mail_rd = b_sel & b_dir_s & b_box_s;
  assign b_fifo_rd = b_sel & b_dir_s & ~b_box_s;

  // ==========================================================
  // mailbox registers and their flags
  logic [35:0] mail_to_b_q;
  logic [35:0] mail_to_a_q;
  logic mail_to_b_flag_q;
  logic mail_to_a_flag_q;

  // held through master reset; only a new write alters contents
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mail_to_b_q <= fifo_mbx_pkg::DATA_ZERO;
    else if (a_mail_wr && mail_to_b_flag_q)
      mail_to_b_q <= a_data_s & lane_mask;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mail_to_a_q <= fifo_mbx_pkg::DATA_ZERO;
    else if (b_mail_wr && mail_to_a_flag_q)
      mail_to_a_q <= b_data_s & lane_mask;
  end

  // a new write wins over a read in the same cycle, so no mail is lost
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mail_to_b_flag_q <= 1'b1;
    else if (in_mrs)
      mail_to_b_flag_q <= 1'b1;
    else if (a_mail_wr && mail_to_b_flag_q)
      mail_to_b_flag_q <= 1'b0;
    else if (b_mail_rd)
      mail_to_b_flag_q <= 1'b1;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mail_to_a_flag_q <= 1'b1;
    else if (in_mrs)
      mail_to_a_flag_q <= 1'b1;
    else if (b_mail_wr && mail_to_a_flag_q)
      mail_to_a_flag_q <= 1'b0;
    else if (a_mail_rd)
      mail_to_a_flag_q <= 1'b1;
  end

  // ==========================================================
  // fifo memory and pointers
  logic [35:0] mem [fifo_mbx_pkg::DEPTH_COUNT];
  logic [fifo_mbx_pkg::PTR_W-1:0] wr_ptr_q;
  logic [fifo_mbx_pkg::PTR_W-1:0] rd_ptr_q;
  logic [fifo_mbx_pkg::PTR_W-1:0] fill;
  logic space_q;
  logic avail_q;
  logic do_write;
  logic do_pop;
  lane_if lane ();

  assign fill = wr_ptr_q - rd_ptr_q;
  assign do_write = a_fifo_wr & space_q;
  // a pop happens only when no narrow piece is left over
  assign do_pop = b_fifo_rd & ~lane.pending & avail_q;

  always_ff @(posedge clock)
  begin
    if (do_write)
      mem[wr_ptr_q[fifo_mbx_pkg::ADDR_W-1:0]] <= a_data_s;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      wr_ptr_q <= fifo_mbx_pkg::PTR_ZERO;
    else if (in_mrs)
      wr_ptr_q <= fifo_mbx_pkg::PTR_ZERO;
    else if (do_write)
      wr_ptr_q <= wr_ptr_q + fifo_mbx_pkg::PTR_ONE;
  end

  // replay assumes the writer stayed below depth since reset
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rd_ptr_q <= fifo_mbx_pkg::PTR_ZERO;
    else if (in_mrs)
      rd_ptr_q <= fifo_mbx_pkg::PTR_ZERO;
    else if (!replay_n_s)
      rd_ptr_q <= fifo_mbx_pkg::PTR_ZERO;
    else if (do_pop)
      rd_ptr_q <= rd_ptr_q + fifo_mbx_pkg::PTR_ONE;
  end

  // flags follow the pointers, including while replay is low
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      space_q <= 1'b0;
      avail_q <= 1'b0;
    end
    else if (in_mrs || mrs_rise)
    begin
      space_q <= 1'b0;
      avail_q <= 1'b0;
    end
    else
    begin
      space_q <= (fill != fifo_mbx_pkg::DEPTH_COUNT);
      avail_q <= (fill != fifo_mbx_pkg::PTR_ZERO);
    end
  end

  // ==========================================================
  // width matching after the memory read
  assign lane.load = do_pop;
  assign lane.advance = b_fifo_rd & lane.pending;
  assign lane.clear = in_mrs | ~replay_n_s;
  assign lane.word = mem[rd_ptr_q[fifo_mbx_pkg::ADDR_W-1:0]];
  assign lane.width = width_q;
  assign lane.big_endian = big_endian_q;

  bus_matcher u_matcher (
    .clock(clock),
    .rstn(rstn),
    .lane(lane)
  );

  // ==========================================================
  // output drivers
  logic [35:0] a_out_q;
  logic [35:0] b_out_q;
  logic a_oe_q;
  logic b_oe_q;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      a_out_q <= fifo_mbx_pkg::DATA_ZERO;
      a_oe_q <= 1'b0;
      b_out_q <= fifo_mbx_pkg::DATA_ZERO;
      b_oe_q <= 1'b0;
    end
    else
    begin
      a_oe_q <= ~a_cs_n_s & ~a_dir_s;
      a_out_q <= mail_to_a_q;
      b_oe_q <= ~b_cs_n_s & b_dir_s;
      b_out_q <= b_box_s ? mail_to_b_q : lane.piece;
    end
  end

  assign port_a_data_out = a_out_q;
  assign port_a_data_oe = a_oe_q;
  assign port_b_data_out = b_out_q;
  assign port_b_data_oe = b_oe_q;
  assign mail_to_b_flag = mail_to_b_flag_q;
  assign mail_to_a_flag = mail_to_a_flag_q;
  assign space_avail_flag = space_q;
  assign fifo_data_flag = avail_q;

endmodule // fifo_mailbox_busmatch_retransmit

// ---- inc/fifo_mbx_pkg.sv ----
// Purpose: shared constants and types for the mailbox / bus-match fifo block
// Assumes: one system clock; port clocks arrive as sampled pins
// Notes: widths and depth are fixed, not parameters
package fifo_mbx_pkg;

  // ==========================================================
  // widths and depth
  localparam int DATA_W = 36;
  localparam int ADDR_W = 10;
  localparam int PTR_W = 11;
  localparam int A_GROUP_W = 41;
  localparam int B_GROUP_W = 41;
  localparam int CFG_GROUP_W = 5;
  localparam logic [10:0] DEPTH_COUNT = 11'h400;
  localparam logic [10:0] PTR_ZERO = 11'h000;
  localparam logic [10:0] PTR_ONE = 11'h001;

  // ==========================================================
  // lane masks per bus size
  localparam logic [35:0] MASK_LONG = 36'hF_FFFF_FFFF;
  localparam logic [35:0] MASK_WORD = 36'h0_0003_FFFF;
  localparam logic [35:0] MASK_BYTE = 36'h0_0000_01FF;
  localparam logic [35:0] DATA_ZERO = 36'h0_0000_0000;

  // ==========================================================
  // piece sequencing: pieces minus one, and lane shifts
  localparam logic [1:0] LAST_LONG = 2'h0;
  localparam logic [1:0] LAST_WORD = 2'h1;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  localparam logic [5:0] SHIFT_WORD = 6'h12;
  localparam logic [5:0] SHIFT_BYTE = 6'h09;

  typedef enum logic [1:0] {
    width_long = 2'b00,
    width_word = 2'b01,
    width_byte = 2'b10
  } bus_width_t;

  // ==========================================================
  // reset values
  localparam bus_width_t WIDTH_RESET = width_long;
  localparam logic ENDIAN_RESET = 1'b1;

endpackage

// ---- inc/lane_if.sv ----
// Purpose: carries fifo long-words into the port b width matcher
// Assumes: single clock domain on both ends
// Notes: load and advance are one-cycle pulses
`timescale 1ns/1ps
interface lane_if;
  logic load;
  logic advance;
  logic clear;
  logic [35:0] word;
  fifo_mbx_pkg::bus_width_t width;
  logic big_endian;
  logic pending;
  logic [35:0] piece;

  modport feeder (
    output load,
    output advance,
    output clear,
    output word,
    output width,
    output big_endian,
    input pending,
    input piece
  );

  modport matcher (
    input load,
    input advance,
    input clear,
    input word,
    input width,
    input big_endian,
    output pending,
    output piece
  );
endinterface

// ---- hw/pin_sync.sv ----
// Purpose: two flip-flop synchroniser for a group of pins
// Assumes: inputs are asynchronous to clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ==========================================================
  // per-bit double flop
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clock or negedge rstn)
    begin
      if (!rstn)
      begin
        meta_q[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else
      begin
        meta_q[i] <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule // pin_sync

// ---- hw/bus_matcher.sv ----
// Purpose: splits a fifo long-word into word or byte pieces for port b
// Assumes: width and endian are static between master resets
// Notes: upper lanes of a piece carry leftover bits, treated as indeterminate
`timescale 1ns/1ps
module bus_matcher (
  input wire logic clock,
  input wire logic rstn,
  lane_if.matcher lane
);

  logic [35:0] word_q;
  logic [35:0] piece_q;
  logic [1:0] left_q;
  logic [1:0] step_q;
  logic [1:0] last;

  // ==========================================================
  // piece selection
  function automatic logic [35:0] slice(
    input logic [35:0] w,
    input fifo_mbx_pkg::bus_width_t wd,
    input logic big,
    input logic [1:0] k,
    input logic [1:0] lst
  );
    logic [1:0] lane_idx;
    logic [5:0] sh;
    lane_idx = big ? (lst - k) : k;
    case (wd)
      fifo_mbx_pkg::width_word: sh = lane_idx[0] ? fifo_mbx_pkg::SHIFT_WORD : 6'h00;
      fifo_mbx_pkg::width_byte: sh = 6'(lane_idx) * fifo_mbx_pkg::SHIFT_BYTE;
      default: sh = 6'h00;
    endcase
    slice = w >> sh;
  endfunction

  always_comb
  begin
    case (lane.width)
      fifo_mbx_pkg::width_word: last = fifo_mbx_pkg::LAST_WORD;
      fifo_mbx_pkg::width_byte: last = fifo_mbx_pkg::LAST_BYTE;
      default: last = fifo_mbx_pkg::LAST_LONG;
    endcase
  end

  // ==========================================================
  // sequencing: first piece on load, rest held in auxiliary word
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      word_q <= fifo_mbx_pkg::DATA_ZERO;
      piece_q <= fifo_mbx_pkg::DATA_ZERO;
      left_q <= 2'h0;
      step_q <= 2'h0;
    end
    else if (lane.clear)
    begin
      left_q <= 2'h0;
      step_q <= 2'h0;
    end
    else if (lane.load)
    begin
      word_q <= lane.word;
      left_q <= last;
      step_q <= 2'h0;
      piece_q <= slice(lane.word, lane.width, lane.big_endian, 2'h0, last);
    end
    else if (lane.advance && left_q != 2'h0)
    begin
      left_q <= left_q - 2'h1;
      step_q <= step_q + 2'h1;
      piece_q <= slice(word_q, lane.width, lane.big_endian, step_q + 2'h1, last);
    end
  end

  assign lane.pending = (left_q != 2'h0);
  assign lane.piece = piece_q;

endmodule // bus_matcher

// ---- bench/fifo_mbx_sva.sv ----
// Purpose: port level checks on mail flags, fifo flags and output enables
// Assumes: pins pass a two stage synchroniser; controls held across port cycles
// Notes: five cycle windows cover synchroniser plus register latency
`timescale 1ns/1ps
module fifo_mbx_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire logic port_a_clock,
  input wire logic port_a_chip_sel_n,
  input wire logic port_a_direction,
  input wire logic port_a_xfer_gate,
  input wire logic port_a_box_select,
  input wire logic port_a_data_oe,
  input wire logic port_b_clock,
  input wire logic port_b_chip_sel_n,
  input wire logic port_b_direction,
  input wire logic port_b_xfer_gate,
  input wire logic port_b_box_select,
  input wire logic port_b_data_oe,
  input wire logic master_reset_pins_n,
  input wire logic replay_strobe_n,
  input wire logic mail_to_b_flag,
  input wire logic mail_to_a_flag,
  input wire logic space_avail_flag,
  input wire logic fifo_data_flag
);
  logic a_go;
  logic b_go;
  // ==========================================================
  // qualified port cycles; port clock is still high when flags react
  assign a_go = port_a_clock && !port_a_chip_sel_n && port_a_xfer_gate;
  assign b_go = port_b_clock && !port_b_chip_sel_n && port_b_xfer_gate;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  to_b_set_a: assert property (
    $fell(mail_to_b_flag) |-> a_go && port_a_direction && port_a_box_select)
    else $error("mail to b flag fell without a port a mail write");
  to_b_clear_a: assert property (
    $rose(mail_to_b_flag) |-> !master_reset_pins_n
      || (b_go && port_b_direction && port_b_box_select))
    else $error("mail to b flag rose without a port b mail read");
  to_a_set_a: assert property (
    $fell(mail_to_a_flag) |-> b_go && !port_b_direction && port_b_box_select)
    else $error("mail to a flag fell without a port b mail write");
  to_a_clear_a: assert property (
    $rose(mail_to_a_flag) |-> !master_reset_pins_n
      || (a_go && !port_a_direction && port_a_box_select))
    else $error("mail to a flag rose without a port a mail read");
  mrs_flags_a: assert property (
    !master_reset_pins_n [*5] |-> mail_to_b_flag && mail_to_a_flag)
    else $error("mail flags not high in master reset");
  mrs_space_a: assert property (
    !master_reset_pins_n [*5] |-> !space_avail_flag)
    else $error("space flag high in master reset");
  data_rise_a: assert property (
    $rose(fifo_data_flag) |-> !replay_strobe_n
      || (a_go && port_a_direction && !port_a_box_select))
    else $error("data flag rose without write or replay");
  data_fall_a: assert property (
    $fell(fifo_data_flag) |-> !master_reset_pins_n
      || (b_go && port_b_direction && !port_b_box_select))
    else $error("data flag fell without a fifo read");
  a_oe_on_a: assert property (
    (!port_a_chip_sel_n && !port_a_direction) [*5] |-> port_a_data_oe)
    else $error("port a outputs off while selected for read");
  a_oe_off_a: assert property (
    port_a_direction [*5] |-> !port_a_data_oe)
    else $error("port a outputs on during write");
  b_oe_on_a: assert property (
    (!port_b_chip_sel_n && port_b_direction) [*5] |-> port_b_data_oe)
    else $error("port b outputs off while selected for read");
  b_oe_off_a: assert property (
    !port_b_direction [*5] |-> !port_b_data_oe)
    else $error("port b outputs on during write");
endmodule // fifo_mbx_sva

// ---- bench/port_agent.sv ----
// Purpose: bus master model for one fifo port, making its clock and controls
// Assumes: port cycle of 160 ns, controls set well before the rising edge
// Notes: clock stands low between transfers; released data lines flip
`timescale 1ns/1ps
module port_agent (
  input wire logic clock,
  output logic pclk,
  output logic cs_n,
  output logic dir,
  output logic gate,
  output logic box,
  output logic [35:0] data
);
  initial
  begin
    pclk = 1'b0;
    cs_n = 1'b1;
    dir = 1'b0;
    gate = 1'b0;
    box = 1'b0;
    data = 36'h0_0000_0000;
  end

  // ==========================================================
  // one port cycle: controls, 80 ns low, 80 ns high, then low; slow callers add gaps
  task automatic xfer(input logic d, input logic g, input logic b, input logic [35:0] w);
    @(posedge clock);
    #1;
    cs_n = 1'b0;
    dir = d;
    gate = g;
    box = b;
    data = w;
    #80;
    pclk = 1'b1;
    #80;
    pclk = 1'b0;
    gate = 1'b0;
    data = ~w;
  endtask
endmodule // port_agent

// ---- bench/fifo_mailbox_busmatch_retransmit_tb.sv ----
// Purpose: self-checking bench for mailbox, bus matching and replay
// Assumes: 100 MHz clock; two port agents make 160 ns port cycles
// Notes: narrow widths leave upper lanes indeterminate, so they are masked
`timescale 1ns/1ps
module fifo_mailbox_busmatch_retransmit_tb;
  logic clock, rstn, port_a_clock, port_a_chip_sel_n, port_a_direction, port_a_xfer_gate;
  logic port_a_box_select, port_b_clock, port_b_chip_sel_n, port_b_direction, port_b_xfer_gate;
  logic port_b_box_select, master_reset_pins_n, bus_match_select, port_b_size_select;
  logic big_endian_select, replay_strobe_n, port_a_data_oe, port_b_data_oe, mail_to_b_flag;
  logic mail_to_a_flag, space_avail_flag, fifo_data_flag, endian;
  logic [35:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out, w;
  logic [35:0] words [4];
  logic [2:0] cfg [5] = '{3'h0, 3'h5, 3'h4, 3'h7, 3'h6};
  int error_cnt, checks, n;

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  fifo_mailbox_busmatch_retransmit fifo_mailbox_busmatch_retransmit_inst (.*);
  port_agent agent_a (.clock(clock), .pclk(port_a_clock), .cs_n(port_a_chip_sel_n),
    .dir(port_a_direction), .gate(port_a_xfer_gate), .box(port_a_box_select),
    .data(port_a_data_in));
  port_agent agent_b (.clock(clock), .pclk(port_b_clock), .cs_n(port_b_chip_sel_n),
    .dir(port_b_direction), .gate(port_b_xfer_gate), .box(port_b_box_select),
    .data(port_b_data_in));

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [35:0] rnd36();
    return {4'($urandom()), $urandom()};
  endfunction

  function automatic logic [35:0] lanes();
    return n == 1 ? fifo_mbx_pkg::MASK_LONG : n == 2 ? fifo_mbx_pkg::MASK_WORD
      : fifo_mbx_pkg::MASK_BYTE;
  endfunction

  // piece k of a long-word in the latched width and order
  function automatic logic [35:0] exp_piece(input logic [35:0] v, input int k);
    int i;
    i = endian ? k : n - 1 - k;
    if (n == 1)
      return v;
    if (n == 2)
      return 36'(v[35 - 18 * i -: 18]);
    return 36'(v[35 - 9 * i -: 9]);
  endfunction

  task automatic mreset(input logic b, input logic s, input logic e);
    @(posedge clock);
    #1;
    bus_match_select = b;
    port_b_size_select = s;
    big_endian_select = e;
    master_reset_pins_n = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    master_reset_pins_n = 1'b1;
    // sample off the edge so the flag is settled when looked at
    for (int i = 0; i < 40 && space_avail_flag !== 1'b1; i++)
    begin
      @(posedge clock);
      #1;
    end
    chk("space flag", 36'h0_0000_0001, 36'(space_avail_flag));
    if (space_avail_flag !== 1'b1)
      end_sim();
    big_endian_select = ~e; // only the latched level counts
    endian = e;
    n = !b ? 1 : s ? 4 : 2;
  endtask

  task automatic read_words(input int cnt);
    for (int j = 0; j < cnt; j++)
      for (int k = 0; k < n; k++)
      begin
        agent_b.xfer(1'b1, 1'b1, 1'b0, words[j]);
        chk("fifo piece", exp_piece(words[j], k) & lanes(), port_b_data_out & lanes());
      end
  endtask

  // ==========================================================
  // main sequence: every width, both endians for word and byte, mail, fifo, replay
  initial
  begin
    rstn = 1'b0;
    master_reset_pins_n = 1'b0;
    bus_match_select = 1'b0;
    port_b_size_select = 1'b0;
    big_endian_select = 1'b1;
    replay_strobe_n = 1'b1;
    error_cnt = 0;
    checks = 0;
    void'($urandom(32'h0115_2631));
    repeat (16) @(posedge clock);
    #1;
    rstn = 1'b1;
    for (int c = 0; c < 5; c++)
    begin
      mreset(cfg[c][2], cfg[c][1], cfg[c][0]);
      chk("flag to b", 36'h0_0000_0001, 36'(mail_to_b_flag));
      chk("flag to a", 36'h0_0000_0001, 36'(mail_to_a_flag));
      w = rnd36();
      agent_a.xfer(1'b1, 1'b1, 1'b1, w);
      chk("flag to b", 36'h0_0000_0000, 36'(mail_to_b_flag));
      agent_a.xfer(1'b1, 1'b1, 1'b1, ~w);
      agent_b.xfer(1'b1, 1'b1, 1'b1, ~w);
      chk("mail to b", w & lanes(), port_b_data_out & lanes());
      chk("flag to b", 36'h0_0000_0001, 36'(mail_to_b_flag));
      agent_b.xfer(1'b0, 1'b1, 1'b1, ~w);
      chk("flag to a", 36'h0_0000_0000, 36'(mail_to_a_flag));
      agent_a.xfer(1'b0, 1'b1, 1'b1, w);
      chk("mail to a", ~w & lanes(), port_a_data_out & lanes());
      chk("flag to a", 36'h0_0000_0001, 36'(mail_to_a_flag));
      for (int i = 0; i < 3; i++)
      begin
        words[i] = rnd36();
        agent_a.xfer(1'b1, 1'b1, 1'b0, words[i]);
      end
      read_words(3);
      chk("data flag", 36'h0_0000_0000, 36'(fifo_data_flag));
      agent_b.xfer(1'b1, 1'b1, 1'b0, w); // empty read keeps last piece
      chk("held piece", exp_piece(words[2], n - 1) & lanes(), port_b_data_out & lanes());
      @(posedge clock);
      #1;
      replay_strobe_n = 1'b0;
      repeat (10) @(posedge clock);
      #1;
      replay_strobe_n = 1'b1;
      repeat (6) @(posedge clock); // gate b idle through recovery
      #1;
      chk("data flag", 36'h0_0000_0001, 36'(fifo_data_flag));
      words[3] = rnd36();
      agent_a.xfer(1'b1, 1'b1, 1'b0, words[3]);
      read_words(4);
      $display("config %0d done, mismatches %0d", c, error_cnt);
    end
    end_sim();
  end
endmodule // fifo_mailbox_busmatch_retransmit_tb

bind fifo_mailbox_busmatch_retransmit fifo_mbx_sva fifo_mbx_sva_inst (.*);
